// File: hdl/mmx_auto_mic_mixer.sv
// automatic microphone mixer core with apb register slave
`timescale 1ns/1ps
module mmx_auto_mic_mixer #(
  parameter int NUM_CH = mmx_pkg::MAX_CH
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         sample_valid,
  input  wire logic [NUM_CH*mmx_pkg::SW-1:0] ch_in,
  input  wire logic [NUM_CH-1:0]            general_input_event,
  output logic                              out_valid,
  output logic      [mmx_pkg::SW-1:0]       out_sample,
  output logic      [3:0]                   open_mic_count,
  output logic      [2*NUM_CH-1:0]          ch_level_band,
  output logic      [2*NUM_CH-1:0]          ch_activity,
  output logic      [1:0]                   out_level_band
);
  import mmx_pkg::*;

  // configuration
  mmx_mode_t         mode     [NUM_CH];
  logic              pri      [NUM_CH];
  logic              mute     [NUM_CH];
  logic [3:0]        lp_sh    [NUM_CH];
  logic [3:0]        hp_sh    [NUM_CH];
  logic [3:0]        avg_sh   [NUM_CH];
  logic [15:0]       thresh   [NUM_CH];
  logic [15:0]       depth    [NUM_CH];
  logic [15:0]       gain     [NUM_CH];
  logic [15:0]       duck     [NUM_CH];
  logic [EW-1:0]     att_step [NUM_CH];
  logic [EW-1:0]     dec_step [NUM_CH];
  logic [EW-1:0]     hold_len [NUM_CH];
  logic              nom_en;
  logic              out_mute;
  logic [3:0]        limit;
  logic [15:0]       out_gain;
  logic [NUM_CH-1:0] trig;
  // processing state
  logic signed [AW-1:0] lp_st  [NUM_CH];
  logic signed [AW-1:0] hp_st  [NUM_CH];
  logic signed [AW-1:0] avg_st [NUM_CH];
  logic [EW-1:0]        hold_cnt [NUM_CH];
  logic [EW-1:0]        env    [NUM_CH];
  logic [EW-1:0]        stamp  [NUM_CH];
  logic [EW-1:0]        seq;
  logic [NUM_CH-1:0]    gate_on;
  logic [NUM_CH-1:0]    cand_q;
  logic [NUM_CH-1:0]    evt_meta;
  logic [NUM_CH-1:0]    evt_sync;
  // next values
  logic signed [AW-1:0] next_lp  [NUM_CH];
  logic signed [AW-1:0] next_hp  [NUM_CH];
  logic signed [AW-1:0] next_avg [NUM_CH];
  logic [NUM_CH-1:0]    qual;
  logic [NUM_CH-1:0]    cand;
  logic [NUM_CH-1:0]    next_gate;
  logic [3:0]           next_count;
  logic signed [AW-1:0] next_mix;
  logic [31:0]          next_rdata;
  logic                 next_err;
  logic                 pri_open;
  logic                 next_pri_open;

  function automatic logic signed [AW-1:0] q15(input logic signed [AW-1:0] a,
                                               input logic [15:0] g);
    logic signed [AW+16:0] p;
    p = a * $signed({1'b0, g});
    return p[AW+14:15];
  endfunction

  function automatic logic signed [AW-1:0] smp(input int i);
    return AW'($signed(ch_in[i*SW +: SW]));
  endfunction

  function automatic logic [1:0] band(input logic signed [AW-1:0] a);
    logic signed [AW-1:0] m;
    m = (a < 0) ? -a : a;
    if (m > $signed({5'h00, LEVEL_TOP})) return BAND_TOP;
    else if (m >= $signed({5'h00, LEVEL_MID})) return BAND_MID;
    else return BAND_LOW;
  endfunction

  // j wins a seat over i: priority, then earlier stamp, then lower index
  function automatic logic beats(input int j, input int i);
    if (pri[j] != pri[i]) return pri[j];
    else if (stamp[j] != stamp[i]) return stamp[j] < stamp[i];
    else return j < i;
  endfunction

  // side chain filtering, averaging and qualification
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_lp[i]  = lp_st[i] + ((smp(i) - lp_st[i]) >>> lp_sh[i]);
      next_hp[i]  = hp_st[i] + ((next_lp[i] - hp_st[i]) >>> hp_sh[i]);
      next_avg[i] = avg_st[i]
                  + ((((next_lp[i] >= next_hp[i]) ? next_lp[i] - next_hp[i]
                                                  : next_hp[i] - next_lp[i])
                     - avg_st[i]) >>> avg_sh[i]);
      qual[i]     = next_avg[i] >= $signed({5'h00, thresh[i]});
    end
  end

  // gate request per detection mode, then limit selection
  always_comb begin
    logic [3:0] ahead;
    logic [3:0] lim;
    ahead      = 4'h0;
    lim        = (limit == 4'h0) ? 4'h1 : ((limit > 4'(NUM_CH)) ? 4'(NUM_CH) : limit);
    next_count = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      case (mode[i])
        MODE_THRESH: cand[i] = qual[i] || hold_cnt[i] != '0;
        MODE_LAST:   cand[i] = qual[i] || hold_cnt[i] != '0
                             || (gate_on[i] && (qual & ~(NUM_CH'(1) << i)) == '0);
        MODE_MANUAL: cand[i] = trig[i] || evt_sync[i];
        default:     cand[i] = 1'b1;
      endcase
    end
    for (int i = 0; i < NUM_CH; i++) begin
      ahead = 4'h0;
      for (int j = 0; j < NUM_CH; j++) begin
        if (j != i && cand[j] && beats(j, i)) ahead = ahead + 4'h1;
      end
      next_gate[i] = cand[i] && ahead < lim;
      if (next_gate[i]) next_count = next_count + 4'h1;
    end
  end

  // priority gates open now and after this sample
  always_comb begin
    pri_open      = 1'b0;
    next_pri_open = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (gate_on[i] && pri[i]) pri_open = 1'b1;
      if (next_gate[i] && pri[i]) next_pri_open = 1'b1;
    end
  end

  // mix of gated, ducked, gained channels into the output bus
  always_comb begin
    logic [15:0]          g;
    logic [EW-1:0]        e;
    logic signed [AW-1:0] acc;
    g   = 16'h0000;
    e   = '0;
    acc = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      e = env[i];
      g = depth[i] + 16'(((32'(GAIN_UNITY - depth[i])) * 32'(e[EW-1:EW-15])) >> 15);
      if (pri_open && !pri[i]) g = 16'(q15(AW'(g), duck[i]));
      g = 16'(q15(AW'(g), gain[i]));
      if (mute[i]) g = 16'h0000;
      acc = acc + q15(smp(i), g);
    end
    if (nom_en) acc = q15(acc, nom_gain(open_mic_count));
    acc = q15(acc, out_gain);
    if (out_mute) acc = '0;
    next_mix = acc;
  end

  // general input event synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_meta <= '0;
      evt_sync <= '0;
    end else begin
      evt_meta <= general_input_event;
      evt_sync <= evt_meta;
    end
  end

  // per-sample state update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        lp_st[i]    <= '0;
        hp_st[i]    <= '0;
        avg_st[i]   <= '0;
        hold_cnt[i] <= '0;
        env[i]      <= '0;
        stamp[i]    <= '0;
      end
      seq            <= '0;
      gate_on        <= '0;
      cand_q         <= '0;
      open_mic_count <= 4'h0;
    end else if (sample_valid) begin
      for (int i = 0; i < NUM_CH; i++) begin
        lp_st[i]  <= next_lp[i];
        hp_st[i]  <= next_hp[i];
        avg_st[i] <= next_avg[i];
        if (qual[i]) hold_cnt[i] <= hold_len[i];
        else if (hold_cnt[i] != '0) hold_cnt[i] <= hold_cnt[i] - EW'(1);
        if (cand[i] && !cand_q[i]) stamp[i] <= seq;
        if (gate_on[i])
          env[i] <= (ENV_FULL - env[i] < att_step[i]) ? ENV_FULL : env[i] + att_step[i];
        else
          env[i] <= (env[i] < dec_step[i]) ? '0 : env[i] - dec_step[i];
      end
      seq            <= seq + EW'(1);
      gate_on        <= next_gate;
      cand_q         <= cand;
      open_mic_count <= next_count;
    end
  end

  // output sample and indicators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid      <= 1'b0;
      out_sample     <= '0;
      out_level_band <= BAND_LOW;
      ch_level_band  <= '0;
      ch_activity    <= '0;
    end else begin
      out_valid <= sample_valid;
      if (sample_valid) begin
        out_sample     <= (next_mix > AW'(32767)) ? 16'h7FFF :
                          (next_mix < -AW'(32768)) ? 16'h8000 : next_mix[SW-1:0];
        out_level_band <= band(next_mix);
        for (int i = 0; i < NUM_CH; i++) begin
          ch_level_band[2*i +: 2] <= band(smp(i));
          ch_activity[2*i +: 2]   <= !next_gate[i] ? ACT_OFF :
                                     (next_pri_open && !pri[i]) ? ACT_DUCKED : ACT_ON;
        end
      end
    end
  end

  // register writes, including settings copy between channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode[i]     <= MODE_THRESH;
        pri[i]      <= 1'b0;
        mute[i]     <= 1'b0;
        lp_sh[i]    <= LP_SHIFT_DEF;
        hp_sh[i]    <= HP_SHIFT_DEF;
        avg_sh[i]   <= AVG_SHIFT_DEF;
        thresh[i]   <= THRESH_DEF;
        depth[i]    <= DEPTH_DEF;
        gain[i]     <= GAIN_UNITY;
        duck[i]     <= DUCK_DEF;
        att_step[i] <= ATTACK_STEP_DEF;
        dec_step[i] <= DECAY_STEP_DEF;
        hold_len[i] <= HOLD_SAMP_DEF;
      end
      nom_en   <= 1'b0;
      out_mute <= 1'b0;
      limit    <= 4'(NUM_CH);
      out_gain <= GAIN_UNITY;
      trig     <= '0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        nom_en   <= pwdata[CTRL_NOM_EN_BIT];
        out_mute <= pwdata[CTRL_OUT_MUTE_BIT];
        limit    <= pwdata[CTRL_LIMIT_LSB +: 4];
      end else if (paddr == ADDR_OUT_GAIN) begin
        out_gain <= pwdata[15:0];
      end else if (paddr == ADDR_TRIG) begin
        trig <= pwdata[NUM_CH-1:0];
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (paddr[11:CH_SEL_LSB] == ADDR_CH_BASE[11:CH_SEL_LSB] + 7'(i)) begin
            logic [2:0] s;
            s = pwdata[CC_SRC_LSB +: 3];
            if (paddr[4:0] == OFF_CH_CTRL && pwdata[CC_COPY_BIT]) begin
              if (32'(s) < NUM_CH) begin
                mode[i]     <= mode[s];
                pri[i]      <= pri[s];
                mute[i]     <= mute[s];
                lp_sh[i]    <= lp_sh[s];
                hp_sh[i]    <= hp_sh[s];
                avg_sh[i]   <= avg_sh[s];
                thresh[i]   <= thresh[s];
                depth[i]    <= depth[s];
                gain[i]     <= gain[s];
                duck[i]     <= duck[s];
                att_step[i] <= att_step[s];
                dec_step[i] <= dec_step[s];
                hold_len[i] <= hold_len[s];
              end
            end else if (paddr[4:0] == OFF_CH_CTRL) begin
              mode[i]   <= mmx_mode_t'(pwdata[CC_MODE_LSB +: 2]);
              pri[i]    <= pwdata[CC_PRI_BIT];
              mute[i]   <= pwdata[CC_MUTE_BIT];
              lp_sh[i]  <= pwdata[CC_LP_LSB +: 4];
              hp_sh[i]  <= pwdata[CC_HP_LSB +: 4];
              avg_sh[i] <= pwdata[CC_AVG_LSB +: 4];
            end else if (paddr[4:0] == OFF_CH_THRESH) begin
              thresh[i] <= pwdata[15:0];
            end else if (paddr[4:0] == OFF_CH_GAIN) begin
              gain[i]  <= pwdata[15:0];
              depth[i] <= pwdata[GAIN_HI_LSB +: 16];
            end else if (paddr[4:0] == OFF_CH_DUCK) begin
              duck[i] <= pwdata[15:0];
            end else if (paddr[4:0] == OFF_CH_ATTACK) begin
              att_step[i] <= pwdata[EW-1:0];
            end else if (paddr[4:0] == OFF_CH_DECAY) begin
              dec_step[i] <= pwdata[EW-1:0];
            end else if (paddr[4:0] == OFF_CH_HOLD) begin
              hold_len[i] <= pwdata[EW-1:0];
            end
          end
        end
      end
    end
  end

  // read data and unmapped-address decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b1;
    if (paddr == ADDR_CTRL) begin
      next_rdata = 32'({limit, 2'b00, out_mute, nom_en});
      next_err   = 1'b0;
    end else if (paddr == ADDR_OUT_GAIN) begin
      next_rdata = 32'(out_gain);
      next_err   = 1'b0;
    end else if (paddr == ADDR_TRIG) begin
      next_rdata = 32'(trig);
      next_err   = 1'b0;
    end else if (paddr == ADDR_STATUS) begin
      next_rdata = 32'({out_level_band, gate_on, open_mic_count});
      next_err   = 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (paddr[11:CH_SEL_LSB] == ADDR_CH_BASE[11:CH_SEL_LSB] + 7'(i)) begin
          next_err = paddr[1:0] != 2'b00;
          if (paddr[4:0] == OFF_CH_CTRL)
            next_rdata = 32'({avg_sh[i], hp_sh[i], lp_sh[i], mute[i], pri[i], mode[i]});
          else if (paddr[4:0] == OFF_CH_THRESH) next_rdata = 32'(thresh[i]);
          else if (paddr[4:0] == OFF_CH_GAIN)   next_rdata = {depth[i], gain[i]};
          else if (paddr[4:0] == OFF_CH_DUCK)   next_rdata = 32'(duck[i]);
          else if (paddr[4:0] == OFF_CH_ATTACK) next_rdata = 32'(att_step[i]);
          else if (paddr[4:0] == OFF_CH_DECAY)  next_rdata = 32'(dec_step[i]);
          else if (paddr[4:0] == OFF_CH_HOLD)   next_rdata = 32'(hold_len[i]);
          else
            next_rdata = 32'({gate_on[i], ch_activity[2*i +: 2], ch_level_band[2*i +: 2]});
        end
      end
    end
  end

  // apb answer: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
      pslverr <= psel && !penable && next_err;
    end
  end

endmodule

// File: hdl/mmx_pkg.sv
// constants, field layouts and types for the automatic microphone mixer
package mmx_pkg;

  // channel and sample geometry
  localparam int MAX_CH = 8;
  localparam int SW     = 16;
  localparam int AW     = 21;
  localparam int EW     = 24;
  localparam int FS_HZ  = 48000;

  // global register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_OUT_GAIN = 12'h004;
  localparam logic [11:0] ADDR_TRIG     = 12'h008;
  localparam logic [11:0] ADDR_STATUS   = 12'h00C;
  localparam logic [11:0] ADDR_CH_BASE  = 12'h100;
  localparam int          CH_SEL_LSB    = 5;

  // per-channel register offsets inside a 32-byte slot
  localparam logic [4:0] OFF_CH_CTRL   = 5'h00;
  localparam logic [4:0] OFF_CH_THRESH = 5'h04;
  localparam logic [4:0] OFF_CH_GAIN   = 5'h08;
  localparam logic [4:0] OFF_CH_DUCK   = 5'h0C;
  localparam logic [4:0] OFF_CH_ATTACK = 5'h10;
  localparam logic [4:0] OFF_CH_DECAY  = 5'h14;
  localparam logic [4:0] OFF_CH_HOLD   = 5'h18;
  localparam logic [4:0] OFF_CH_STATUS = 5'h1C;

  // global control fields
  localparam int CTRL_NOM_EN_BIT   = 0;
  localparam int CTRL_OUT_MUTE_BIT = 1;
  localparam int CTRL_LIMIT_LSB    = 4;

  // channel control fields
  localparam int CC_MODE_LSB  = 0;
  localparam int CC_PRI_BIT   = 2;
  localparam int CC_MUTE_BIT  = 3;
  localparam int CC_LP_LSB    = 4;
  localparam int CC_HP_LSB    = 8;
  localparam int CC_AVG_LSB   = 12;
  localparam int CC_SRC_LSB   = 16;
  localparam int CC_COPY_BIT  = 31;
  localparam int GAIN_HI_LSB  = 16;

  // level values in Q15 linear amplitude
  localparam logic [15:0] GAIN_UNITY  = 16'h7FFF;
  localparam logic [15:0] THRESH_DEF  = 16'h0068;
  localparam logic [15:0] DEPTH_DEF   = 16'h000A;
  localparam logic [15:0] DUCK_DEF    = 16'h066A;
  localparam logic [15:0] LEVEL_MID   = 16'h0CCD;
  localparam logic [15:0] LEVEL_TOP   = 16'h4026;

  // side chain shift coefficients (time constant = 2^shift samples)
  localparam logic [3:0] LP_SHIFT_DEF  = 4'h0;
  localparam logic [3:0] HP_SHIFT_DEF  = 4'h5;
  localparam logic [3:0] AVG_SHIFT_DEF = 4'hB;

  // default times and their sample counts
  localparam int ATTACK_DEF_US = 500;
  localparam int DECAY_DEF_MS  = 1000;
  localparam int HOLD_DEF_MS   = 2000;
  localparam int ENV_SPAN      = 1 << EW;
  localparam int ATTACK_SAMP   = (ATTACK_DEF_US * FS_HZ) / 1000000;
  localparam int DECAY_SAMP    = (DECAY_DEF_MS * FS_HZ) / 1000;
  localparam logic [EW-1:0] ATTACK_STEP_DEF = EW'((ENV_SPAN + ATTACK_SAMP - 1) / ATTACK_SAMP);
  localparam logic [EW-1:0] DECAY_STEP_DEF  = EW'(ENV_SPAN / DECAY_SAMP);
  localparam logic [EW-1:0] HOLD_SAMP_DEF   = EW'((HOLD_DEF_MS * FS_HZ) / 1000);
  localparam logic [EW-1:0] ENV_FULL        = 24'hFFFFFF;

  typedef enum logic [1:0] {MODE_THRESH, MODE_LAST, MODE_MANUAL, MODE_BYPASS} mmx_mode_t;
  typedef enum logic [1:0] {ACT_OFF, ACT_ON, ACT_DUCKED} mmx_act_t;
  typedef enum logic [1:0] {BAND_LOW, BAND_MID, BAND_TOP} mmx_band_t;

  // 1/sqrt(n) in Q15: amplitude for -10*log10(n) dB
  function automatic logic [15:0] nom_gain(input logic [3:0] n);
    case (n)
      4'h2:    return 16'h5A82;
      4'h3:    return 16'h49E7;
      4'h4:    return 16'h4000;
      4'h5:    return 16'h393E;
      4'h6:    return 16'h3441;
      4'h7:    return 16'h3061;
      4'h8:    return 16'h2D41;
      default: return GAIN_UNITY;
    endcase
  endfunction

endpackage

// File: sim/mmx_audio_src.sv
// upstream sample source and trigger inputs for the mixer
`timescale 1ns/1ps
module mmx_audio_src #(
  parameter int NUM_CH = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              run,
  input wire logic [15:0]       amp,
  input wire logic [NUM_CH-1:0] trig,
  output logic                  sample_valid,
  output logic [NUM_CH*16-1:0]  ch_in,
  output logic [NUM_CH-1:0]     general_input_event
);
  logic [1:0] phase;
  logic       neg;
  // one sample every four clocks, sign alternating; junk on the bus in between
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      neg <= 1'b0;
      sample_valid <= 1'b0;
      ch_in <= '0;
      general_input_event <= '0;
    end else begin
      phase <= phase + 2'h1;
      sample_valid <= run && phase == 2'h3;
      general_input_event <= trig;
      if (run && phase == 2'h3) begin
        neg <= !neg;
        ch_in <= {NUM_CH{neg ? 16'(-amp) : amp}};
      end else begin
        ch_in <= ~ch_in;
      end
    end
  end
endmodule

// File: sim/mmx_chk.sv
// port checker for the automatic microphone mixer
`timescale 1ns/1ps
module mmx_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                sample_valid,
  input wire logic                out_valid,
  input wire logic [15:0]         out_sample,
  input wire logic [3:0]          open_mic_count,
  input wire logic [2*NUM_CH-1:0] ch_activity
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] n_open;
  // number of channels whose activity shows an open gate
  always_comb begin
    n_open = 4'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      n_open = n_open + 4'(ch_activity[2*i +: 2] != 2'h0);
    end
  end
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_rdz; !pready |-> prdata == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside access");
  property p_ov; sample_valid |=> out_valid; endproperty
  a_ov: assert property (p_ov) else $error("no output one cycle after sample");
  property p_ovc; out_valid |-> $past(sample_valid); endproperty
  a_ovc: assert property (p_ovc) else $error("output without a sample");
  property p_hold; !out_valid |-> $stable(out_sample) && $stable(open_mic_count); endproperty
  a_hold: assert property (p_hold) else $error("output moved between samples");
  property p_lim; open_mic_count <= 4'(NUM_CH); endproperty
  a_lim: assert property (p_lim) else $error("open count above channel count");
  property p_cnt; out_valid |-> open_mic_count == n_open; endproperty
  a_cnt: assert property (p_cnt) else $error("open count differs from activity");
  c_duck: cover property (ch_activity[3:2] == 2'h2);
  c_err: cover property (pslverr);
  c_one: cover property (out_valid && open_mic_count == 4'h1);
endmodule

// File: sim/tb_mmx_auto_mic_mixer.sv
// self-checking bench for the automatic microphone mixer
`timescale 1ns/1ps
module tb_mmx_auto_mic_mixer;
  import mmx_pkg::*;
  localparam int NUM_CH = 8;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} mmx_row_t;
  logic                 pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, run = 1'b0, pready, pslverr, sample_valid, out_valid, err;
  logic [11:0]          paddr = '0;
  logic [31:0]          pwdata = '0, prdata, rd;
  logic [15:0]          amp = '0, out_sample;
  logic [NUM_CH-1:0]    trig = '0, gie;
  logic [NUM_CH*16-1:0] ch_in;
  logic [3:0]           open_mic_count;
  logic [2*NUM_CH-1:0]  ch_level_band, ch_activity;
  logic [1:0]           out_level_band;
  int                   num_errors = 0, checked = 0;
  mmx_row_t rows[12] = '{
    '{12'h000, 32'h00000080, 1'b0},
    '{12'h004, 32'(GAIN_UNITY), 1'b0},
    '{12'h00C, 32'h00000000, 1'b0},
    '{12'h100, {16'h0, AVG_SHIFT_DEF, HP_SHIFT_DEF, LP_SHIFT_DEF, 4'h0}, 1'b0},
    '{12'h104, 32'(THRESH_DEF), 1'b0},
    '{12'h108, {DEPTH_DEF, GAIN_UNITY}, 1'b0},
    '{12'h10C, 32'(DUCK_DEF), 1'b0},
    '{12'h110, 32'(ATTACK_STEP_DEF), 1'b0},
    '{12'h114, 32'(DECAY_STEP_DEF), 1'b0},
    '{12'h118, 32'(HOLD_SAMP_DEF), 1'b0},
    '{12'h1E8, {DEPTH_DEF, GAIN_UNITY}, 1'b0},
    '{12'h800, 32'h00000000, 1'b1}};
  mmx_auto_mic_mixer #(.NUM_CH(NUM_CH)) i_mmx_auto_mic_mixer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .ch_in(ch_in), .general_input_event(gie), .out_valid(out_valid), .out_sample(out_sample),
    .open_mic_count(open_mic_count), .ch_level_band(ch_level_band),
    .ch_activity(ch_activity), .out_level_band(out_level_band));
  mmx_audio_src #(.NUM_CH(NUM_CH)) i_mmx_audio_src (.pclk(pclk), .presetn(presetn), .run(run),
    .amp(amp), .trig(trig), .sample_valid(sample_valid), .ch_in(ch_in),
    .general_input_event(gie));
  always #2.5 pclk = ~pclk;
  // verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // wait for k mixed samples, bounded
  task automatic samples(input int k);
    int n;
    n = 0;
    repeat (k) begin
      do begin
        @(posedge pclk);
        n++;
      end while (out_valid !== 1'b1 && n < 4000);
    end
    if (n >= 4000) begin
      num_errors++;
      wrap_up();
    end
  endtask
  initial begin
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      cmp(rd, rows[i].d);
      cmp(32'(err), 32'(rows[i].e));
    end
    // priority bypass on ch0, copied to ch5, plain bypass on ch1
    apb(1'b1, 12'h100, 32'h7);
    apb(1'b1, 12'h1A0, 32'h80000000);
    apb(1'b0, 12'h1A0, 32'h0);
    cmp(rd, 32'h7);
    apb(1'b1, 12'h120, 32'h3);
    run <= 1'b1;
    samples(8);
    cmp(32'(ch_activity), 32'h0409);
    cmp(32'(open_mic_count), 32'h3);
    apb(1'b1, 12'h000, 32'h20);
    samples(4);
    cmp(32'(ch_activity), 32'h0401);
    apb(1'b1, 12'h000, 32'h10);
    samples(4);
    cmp(32'(ch_activity), 32'h0001);
    // ch5 manual: input event, then software trigger, then none
    apb(1'b1, 12'h000, 32'h80);
    apb(1'b1, 12'h1A0, 32'h2);
    trig <= 8'h20;
    samples(4);
    cmp(32'(ch_activity[11:10]), 32'h2);
    trig <= 8'h00;
    apb(1'b1, 12'h008, 32'h20);
    samples(4);
    cmp(32'(ch_activity[11:10]), 32'h2);
    apb(1'b1, 12'h008, 32'h0);
    samples(4);
    cmp(32'(ch_activity[11:10]), 32'h0);
    // ch2 threshold, low-pass off, high-pass shift 1, one-sample hold
    apb(1'b1, 12'h140, 32'h100);
    apb(1'b1, 12'h158, 32'h1);
    amp <= 16'h5000;
    samples(6);
    cmp(32'(ch_activity[5:4]), 32'h2);
    cmp(32'(ch_level_band[5:4]), 32'h2);
    amp <= 16'h1000;
    samples(6);
    cmp(32'(ch_level_band[5:4]), 32'h1);
    amp <= 16'h0;
    samples(8);
    cmp(32'(ch_activity[5:4]), 32'h0);
    // output band: plain, halved gain, open-count attenuation
    amp <= 16'h1000;
    samples(6);
    cmp(32'(out_level_band), 32'h1);
    apb(1'b1, 12'h004, 32'h4000);
    samples(4);
    cmp(32'(out_level_band), 32'h0);
    apb(1'b1, 12'h004, 32'h7FFF);
    apb(1'b1, 12'h000, 32'h81);
    samples(4);
    cmp(32'(out_level_band), 32'h0);
    // ch2 hold-last stays open while no other channel qualifies
    apb(1'b1, 12'h140, 32'h101);
    amp <= 16'h0;
    samples(8);
    cmp(32'(ch_activity[5:4]), 32'h2);
    apb(1'b1, 12'h000, 32'h82);
    amp <= 16'h1000;
    samples(4);
    cmp(32'(out_sample), 32'h0);
    wrap_up();
  end
endmodule
bind mmx_auto_mic_mixer mmx_chk #(.NUM_CH(NUM_CH)) i_mmx_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .out_valid(out_valid), .out_sample(out_sample),
  .open_mic_count(open_mic_count), .ch_activity(ch_activity));
